/* File: hdl/chan_ctrl_map.vh */
// Register offsets, reset values and timing constants of the per-channel
// idle-code substitution and channel-blocking block.
// Assumes an 8-bit host port and bit-serial backplane streams on one clock.
// Functional notes
// - 82h enables tx idle code, channels 17-24
// - 83h enables tx idle code, channels 25-32
// - 84h enables rx idle code, channels 1-8
// - 85h enables rx idle code, channels 9-16
// - 86h enables rx idle code, channels 17-24
// - 87h enables rx idle code, channels 25-32
// - Blocking registers drive each direction's blocking output
// - Set bit holds output high whole channel
// - T1 mode ignores blocking of channels 25-32
// - 88h holds rx blocking, channels 1-8
// - 89h holds rx blocking, channels 9-16
// - 8Ah holds rx blocking, channels 17-24
// - 8Bh holds rx blocking, channels 25-32
// - 8Ch holds tx blocking, channels 1-8
// - Substituted byte comes from array, LSB last
// - 80h and 81h enable tx idle code, channels 1-16
`ifndef CHAN_CTRL_MAP_VH
`define CHAN_CTRL_MAP_VH

// Idle array pointer and code port
`define CC_ADDR_IDLE_PTR     8'h7e
`define CC_ADDR_IDLE_CODE    8'h7f
// Idle-code insertion enables
`define CC_ADDR_TX_INS_1_8   8'h80
`define CC_ADDR_TX_INS_9_16  8'h81
`define CC_ADDR_TX_INS_17_24 8'h82
`define CC_ADDR_TX_INS_25_32 8'h83
`define CC_ADDR_RX_INS_1_8   8'h84
`define CC_ADDR_RX_INS_9_16  8'h85
`define CC_ADDR_RX_INS_17_24 8'h86
`define CC_ADDR_RX_INS_25_32 8'h87
// Channel blocking
`define CC_ADDR_RX_BLK_1_8   8'h88
`define CC_ADDR_RX_BLK_9_16  8'h89
`define CC_ADDR_RX_BLK_17_24 8'h8a
`define CC_ADDR_RX_BLK_25_32 8'h8b
`define CC_ADDR_TX_BLK_1_8   8'h8c
`define CC_ADDR_TX_BLK_9_16  8'h8d
`define CC_ADDR_TX_BLK_17_24 8'h8e
`define CC_ADDR_TX_BLK_25_32 8'h8f

// Pointer register fields
`define CC_PTR_GLOBAL_RX_BIT 7
`define CC_PTR_GLOBAL_TX_BIT 6
`define CC_PTR_ADDR_MSB      5
`define CC_PTR_RX_BASE       6'h20

// Reset values
`define CC_RST_BYTE          8'h00
`define CC_RST_WORD          32'h0000_0000
`define CC_RST_PTR           8'h00
`define CC_RST_CODE          8'h00

// Read answer for an unmapped address
`define CC_UNMAPPED_DATA     8'h00

// Frame timing
`define CC_T1_CHANNELS       5'd24
`define CC_T1_LAST_CHAN      5'd23
`define CC_LAST_BIT          3'd7
`define CC_FIRST_BIT         3'd0

`endif

/* File: hdl/chan_slot_path.v */
// One direction of the backplane stream: channel timing, idle-code
// substitution and the channel-blocking output.
// Assumes bit strobes and frame sync come from logic on the same clock.
`timescale 1ns/100ps
`include "chan_ctrl_map.vh"

module chan_slot_path (
    input  wire         clk,
    input  wire         rst,
    input  wire         t1_mode,
    input  wire         bit_en,
    input  wire         frame_sync,
    input  wire         data_in,
    input  wire [31:0]  ins_en,
    input  wire [31:0]  blk_en,
    input  wire [255:0] codes,
    output reg          data_out,
    output reg          chblk
);

    reg  [2:0] bit_q;
    reg  [4:0] chan_q;
    reg        fbit_q;
    reg  [7:0] shift_q;
    reg        sub_q;

    wire       cur_fbit;
    wire [4:0] cur_chan;
    wire [2:0] cur_bit;
    wire       cur_first;
    wire       in_frame;
    wire [7:0] code_sel;
    wire       new_sub;
    wire       new_blk;
    wire       sub_now;
    wire       code_bit;

    // Frame sync marks the F bit in T1 and bit 0 of channel 1 in E1
    assign cur_fbit  = frame_sync ? t1_mode : fbit_q;
    assign cur_chan  = frame_sync ? 5'd0 : chan_q;
    assign cur_bit   = frame_sync ? `CC_FIRST_BIT : bit_q;
    assign cur_first = !cur_fbit && (cur_bit == `CC_FIRST_BIT);
    assign in_frame  = !t1_mode || (cur_chan < `CC_T1_CHANNELS);
    assign code_sel  = codes[{cur_chan, 3'b000} +: 8];
    assign new_sub   = ins_en[cur_chan] && in_frame;
    assign new_blk   = blk_en[cur_chan] && in_frame;
    // F bit passes through even when the slot before it was substituted
    assign sub_now   = !cur_fbit && (cur_first ? new_sub : sub_q);
    // Code goes out MSB first so its LSB is the last bit of the slot
    assign code_bit  = cur_first ? code_sel[7]
                                 : shift_q[`CC_LAST_BIT - cur_bit];

    always @(posedge clk) begin
        if (rst) begin
            bit_q  <= `CC_FIRST_BIT;
            chan_q <= 5'd0;
            fbit_q <= 1'b0;
        end else if (bit_en) begin
            if (cur_fbit) begin
                fbit_q <= 1'b0;
                chan_q <= 5'd0;
                bit_q  <= `CC_FIRST_BIT;
            end else begin
                bit_q <= cur_bit + 3'd1;
                if (cur_bit == `CC_LAST_BIT) begin
                    if (t1_mode && cur_chan == `CC_T1_LAST_CHAN) begin
                        fbit_q <= 1'b1;
                        chan_q <= 5'd0;
                    end else begin
                        chan_q <= cur_chan + 5'd1;
                    end
                end else begin
                    chan_q <= cur_chan;
                end
            end
        end
    end

    // Enables and code are latched at the first bit so a host write in
    // mid-slot cannot tear a byte or glitch the blocking level
    always @(posedge clk) begin
        if (rst) begin
            shift_q  <= `CC_RST_CODE;
            sub_q    <= 1'b0;
            chblk    <= 1'b0;
            data_out <= 1'b0;
        end else if (bit_en) begin
            data_out <= sub_now ? code_bit : data_in;
            if (cur_fbit) begin
                sub_q <= 1'b0;
                chblk <= 1'b0;
            end else if (cur_first) begin
                shift_q <= code_sel;
                sub_q   <= new_sub;
                chblk   <= new_blk;
            end
        end
    end

endmodule

/* File: hdl/chan_ctrl.v */
// Host register bank for per-channel idle-code substitution and channel
// blocking of one transceiver, with one stream path per direction.
// Assumes the host port and the backplane timing share CLOCK.
`timescale 1ns/100ps
`include "chan_ctrl_map.vh"

module chan_ctrl (
    input  wire       CLOCK,
    input  wire       RESET,
    input  wire [7:0] HOST_ADDR,
    input  wire [7:0] HOST_WDATA,
    input  wire       HOST_WR,
    input  wire       HOST_RD,
    output reg  [7:0] HOST_RDATA,
    input  wire       T1_MODE,
    input  wire       TX_BIT_EN,
    input  wire       TX_FRAME_SYNC,
    input  wire       TX_DATA_IN,
    output wire       TX_DATA_OUT,
    output wire       TX_CHANNEL_BLOCK_OUT,
    input  wire       RX_BIT_EN,
    input  wire       RX_FRAME_SYNC,
    input  wire       RX_DATA_IN,
    output wire       RX_DATA_OUT,
    output wire       RX_CHANNEL_BLOCK_OUT
);

    // Insertion enables and blocking bits, bit n is channel n+1
    reg  [31:0]  tx_ins_q;
    reg  [31:0]  rx_ins_q;
    reg  [31:0]  rx_blk_q;
    reg  [31:0]  tx_blk_q;

    // Idle array pointer: global rx, global tx, six-bit entry address
    reg  [7:0]   idle_array_pointer_q;
    reg  [7:0]   idle_array_pointer_d;

    // Entries 0-31 are transmit channels, 32-63 receive channels
    reg  [7:0]   code_q [0:63];

    wire [5:0]   ptr_addr;
    wire [5:0]   ptr_inc;
    wire         global_tx;
    wire         global_rx;
    wire         code_wr;
    wire [255:0] tx_codes;
    wire [255:0] rx_codes;

    reg  [7:0]   rdata_d;
    integer      i;

    assign ptr_addr  = idle_array_pointer_q[`CC_PTR_ADDR_MSB:0];
    assign ptr_inc   = ptr_addr + 6'h01;
    assign global_tx = idle_array_pointer_q[`CC_PTR_GLOBAL_TX_BIT];
    assign global_rx = idle_array_pointer_q[`CC_PTR_GLOBAL_RX_BIT];
    assign code_wr   = HOST_WR && (HOST_ADDR == `CC_ADDR_IDLE_CODE);

    // Enable and blocking registers
    always @(posedge CLOCK) begin
        if (RESET) begin
            tx_ins_q <= `CC_RST_WORD;
            rx_ins_q <= `CC_RST_WORD;
            rx_blk_q <= `CC_RST_WORD;
            tx_blk_q <= `CC_RST_WORD;
        end else if (HOST_WR) begin
            case (HOST_ADDR)
                `CC_ADDR_TX_INS_1_8: begin
                    tx_ins_q[7:0] <= HOST_WDATA;
                end
                `CC_ADDR_TX_INS_9_16: begin
                    tx_ins_q[15:8] <= HOST_WDATA;
                end
                `CC_ADDR_TX_INS_17_24: begin
                    tx_ins_q[23:16] <= HOST_WDATA;
                end
                `CC_ADDR_TX_INS_25_32: begin
                    tx_ins_q[31:24] <= HOST_WDATA;
                end
                `CC_ADDR_RX_INS_1_8: begin
                    rx_ins_q[7:0] <= HOST_WDATA;
                end
                `CC_ADDR_RX_INS_9_16: begin
                    rx_ins_q[15:8] <= HOST_WDATA;
                end
                `CC_ADDR_RX_INS_17_24: begin
                    rx_ins_q[23:16] <= HOST_WDATA;
                end
                `CC_ADDR_RX_INS_25_32: begin
                    rx_ins_q[31:24] <= HOST_WDATA;
                end
                `CC_ADDR_RX_BLK_1_8: begin
                    rx_blk_q[7:0] <= HOST_WDATA;
                end
                `CC_ADDR_RX_BLK_9_16: begin
                    rx_blk_q[15:8] <= HOST_WDATA;
                end
                `CC_ADDR_RX_BLK_17_24: begin
                    rx_blk_q[23:16] <= HOST_WDATA;
                end
                `CC_ADDR_RX_BLK_25_32: begin
                    rx_blk_q[31:24] <= HOST_WDATA;
                end
                `CC_ADDR_TX_BLK_1_8: begin
                    tx_blk_q[7:0] <= HOST_WDATA;
                end
                `CC_ADDR_TX_BLK_9_16: begin
                    tx_blk_q[15:8] <= HOST_WDATA;
                end
                `CC_ADDR_TX_BLK_17_24: begin
                    tx_blk_q[23:16] <= HOST_WDATA;
                end
                `CC_ADDR_TX_BLK_25_32: begin
                    tx_blk_q[31:24] <= HOST_WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    // Pointer steps after each single-entry code write so a run of writes
    // fills consecutive channels; global writes leave it where it is
    always @* begin
        idle_array_pointer_d = idle_array_pointer_q;
        if (HOST_WR && HOST_ADDR == `CC_ADDR_IDLE_PTR) begin
            idle_array_pointer_d = HOST_WDATA;
        end else if (code_wr && !global_tx && !global_rx) begin
            idle_array_pointer_d = {idle_array_pointer_q[7:6], ptr_inc};
        end
    end

    always @(posedge CLOCK) begin
        if (RESET) begin
            idle_array_pointer_q <= `CC_RST_PTR;
        end else begin
            idle_array_pointer_q <= idle_array_pointer_d;
        end
    end

    // Idle-code array in flip-flops
    always @(posedge CLOCK) begin
        if (RESET) begin
            for (i = 0; i < 64; i = i + 1) begin
                code_q[i] <= `CC_RST_CODE;
            end
        end else if (code_wr) begin
            if (global_tx || global_rx) begin
                for (i = 0; i < 32; i = i + 1) begin
                    if (global_tx) begin
                        code_q[i] <= HOST_WDATA;
                    end
                    if (global_rx) begin
                        code_q[i + 32] <= HOST_WDATA;
                    end
                end
            end else begin
                code_q[ptr_addr] <= HOST_WDATA;
            end
        end
    end

    // Flatten the array halves for the two stream paths
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : flat
            assign tx_codes[g*8 +: 8] = code_q[g];
            assign rx_codes[g*8 +: 8] = code_q[g + 32];
        end
    endgenerate

    // Read mux; data appears the cycle after the read strobe
    always @* begin
        rdata_d = `CC_UNMAPPED_DATA;
        case (HOST_ADDR)
            `CC_ADDR_IDLE_PTR: begin
                rdata_d = idle_array_pointer_q;
            end
            `CC_ADDR_IDLE_CODE: begin
                rdata_d = code_q[ptr_addr];
            end
            `CC_ADDR_TX_INS_1_8: begin
                rdata_d = tx_ins_q[7:0];
            end
            `CC_ADDR_TX_INS_9_16: begin
                rdata_d = tx_ins_q[15:8];
            end
            `CC_ADDR_TX_INS_17_24: begin
                rdata_d = tx_ins_q[23:16];
            end
            `CC_ADDR_TX_INS_25_32: begin
                rdata_d = tx_ins_q[31:24];
            end
            `CC_ADDR_RX_INS_1_8: begin
                rdata_d = rx_ins_q[7:0];
            end
            `CC_ADDR_RX_INS_9_16: begin
                rdata_d = rx_ins_q[15:8];
            end
            `CC_ADDR_RX_INS_17_24: begin
                rdata_d = rx_ins_q[23:16];
            end
            `CC_ADDR_RX_INS_25_32: begin
                rdata_d = rx_ins_q[31:24];
            end
            `CC_ADDR_RX_BLK_1_8: begin
                rdata_d = rx_blk_q[7:0];
            end
            `CC_ADDR_RX_BLK_9_16: begin
                rdata_d = rx_blk_q[15:8];
            end
            `CC_ADDR_RX_BLK_17_24: begin
                rdata_d = rx_blk_q[23:16];
            end
            `CC_ADDR_RX_BLK_25_32: begin
                rdata_d = rx_blk_q[31:24];
            end
            `CC_ADDR_TX_BLK_1_8: begin
                rdata_d = tx_blk_q[7:0];
            end
            `CC_ADDR_TX_BLK_9_16: begin
                rdata_d = tx_blk_q[15:8];
            end
            `CC_ADDR_TX_BLK_17_24: begin
                rdata_d = tx_blk_q[23:16];
            end
            `CC_ADDR_TX_BLK_25_32: begin
                rdata_d = tx_blk_q[31:24];
            end
            default: begin
                rdata_d = `CC_UNMAPPED_DATA;
            end
        endcase
    end

    // Read data holds until the next read strobe
    always @(posedge CLOCK) begin
        if (RESET) begin
            HOST_RDATA <= `CC_UNMAPPED_DATA;
        end else if (HOST_RD) begin
            HOST_RDATA <= rdata_d;
        end
    end

    // Each direction follows its own frame and channel timing
    chan_slot_path tx_path (
        .clk        (CLOCK),
        .rst        (RESET),
        .t1_mode    (T1_MODE),
        .bit_en     (TX_BIT_EN),
        .frame_sync (TX_FRAME_SYNC),
        .data_in    (TX_DATA_IN),
        .ins_en     (tx_ins_q),
        .blk_en     (tx_blk_q),
        .codes      (tx_codes),
        .data_out   (TX_DATA_OUT),
        .chblk      (TX_CHANNEL_BLOCK_OUT)
    );

    chan_slot_path rx_path (
        .clk        (CLOCK),
        .rst        (RESET),
        .t1_mode    (T1_MODE),
        .bit_en     (RX_BIT_EN),
        .frame_sync (RX_FRAME_SYNC),
        .data_in    (RX_DATA_IN),
        .ins_en     (rx_ins_q),
        .blk_en     (rx_blk_q),
        .codes      (rx_codes),
        .data_out   (RX_DATA_OUT),
        .chblk      (RX_CHANNEL_BLOCK_OUT)
    );

endmodule

/* File: testbench/chan_ctrl_props.sv */
// Checker for the channel control block, watching its top ports only.
// Assumes it is bound into chan_ctrl; boundary checks use E1 timing.
`timescale 1ns/100ps
module chan_ctrl_props (
    input wire       CLOCK,
    input wire       RESET,
    input wire [7:0] HOST_ADDR,
    input wire [7:0] HOST_WDATA,
    input wire       HOST_WR,
    input wire       HOST_RD,
    input wire [7:0] HOST_RDATA,
    input wire       T1_MODE,
    input wire       TX_BIT_EN,
    input wire       TX_FRAME_SYNC,
    input wire       TX_CHANNEL_BLOCK_OUT,
    input wire       TX_DATA_OUT,
    input wire       RX_BIT_EN,
    input wire       RX_FRAME_SYNC,
    input wire       RX_DATA_IN,
    input wire       RX_DATA_OUT,
    input wire       RX_CHANNEL_BLOCK_OUT
);
    reg [7:0] tpos_q;
    reg [7:0] rpos_q;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Position of the last bit taken, free running between syncs
    always @(posedge CLOCK) begin
        if (RESET) begin
            tpos_q <= 8'hff;
            rpos_q <= 8'hff;
        end else begin
            if (TX_BIT_EN)
                tpos_q <= TX_FRAME_SYNC ? 8'h00 : tpos_q + 8'h01;
            if (RX_BIT_EN)
                rpos_q <= RX_FRAME_SYNC ? 8'h00 : rpos_q + 8'h01;
        end
    end
    a_tx_hold: assert property (!$past(TX_BIT_EN) |->
        $stable({TX_DATA_OUT, TX_CHANNEL_BLOCK_OUT}))
        else $error("tx outputs moved without a strobe");
    a_rx_hold: assert property (!$past(RX_BIT_EN) |->
        $stable({RX_DATA_OUT, RX_CHANNEL_BLOCK_OUT}))
        else $error("rx outputs moved without a strobe");
    a_tx_blk_edge: assert property (!T1_MODE &&
        $changed(TX_CHANNEL_BLOCK_OUT) |-> tpos_q[2:0] == 3'h0)
        else $error("tx block changed inside a channel");
    a_rx_blk_edge: assert property (!T1_MODE &&
        $changed(RX_CHANNEL_BLOCK_OUT) |-> rpos_q[2:0] == 3'h0)
        else $error("rx block changed inside a channel");
    a_tx_fbit_low: assert property (T1_MODE &&
        $past(T1_MODE && TX_BIT_EN && TX_FRAME_SYNC) |->
        !TX_CHANNEL_BLOCK_OUT)
        else $error("tx block high in framing bit");
    a_rx_fbit_pass: assert property (T1_MODE &&
        $past(T1_MODE && RX_BIT_EN && RX_FRAME_SYNC) |->
        RX_DATA_OUT == $past(RX_DATA_IN) && !RX_CHANNEL_BLOCK_OUT)
        else $error("rx framing bit altered");
    a_rdata_hold: assert property (!$past(HOST_RD) |->
        $stable(HOST_RDATA))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (HOST_RD && HOST_ADDR == 8'h10 |=>
        HOST_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_wr_rd_back: assert property (HOST_WR && HOST_ADDR[7:4] == 4'h8
        ##1 !HOST_WR ##1 HOST_RD && HOST_ADDR == $past(HOST_ADDR, 2)
        |=> HOST_RDATA == $past(HOST_WDATA, 3))
        else $error("register read back differs");
endmodule

/* File: testbench/bp_stream_src.sv */
// Backplane stream source: bit strobes, frame sync, position and data.
// Assumes the block's clock; one strobe every GAP cycles.
`timescale 1ns/100ps
module bp_stream_src #(
    parameter [3:0] GAP = 4'h2
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       t1,
    output wire       bit_en,
    output wire       sync,
    output wire       data,
    output wire [7:0] pos
);
    reg  [3:0] gap_q;
    reg        en_q;
    reg  [7:0] pos_q;
    wire [7:0] last = t1 ? 8'hc0 : 8'hff;
    assign bit_en = en_q;
    assign pos    = pos_q;
    assign sync   = en_q && pos_q == 8'h00;
    // Data alternates within each group of eight positions and inverts between groups so a stuck output cannot pass
    assign data   = pos_q[0] ~^ pos_q[3];
    always @(posedge clk) begin
        if (rst) begin
            gap_q <= 4'h0;
            en_q  <= 1'b0;
            pos_q <= 8'h00;
        end else begin
            gap_q <= (gap_q == GAP - 4'h1) ? 4'h0 : gap_q + 4'h1;
            en_q  <= (gap_q == GAP - 4'h1);
            // A mode change mid-frame still wraps
            if (en_q)
                pos_q <= (pos_q >= last) ? 8'h00 : pos_q + 8'h01;
        end
    end
endmodule

/* File: testbench/chan_ctrl_bench.sv */
// Self-checking bench: host registers and both backplane streams.
// Assumes two stream sources and the bound property checker.
`timescale 1ns/100ps
module chan_ctrl_bench;
    reg        CLOCK = 1'b0;
    reg        RESET = 1'b1;
    reg  [7:0] HOST_ADDR = 8'h00;
    reg  [7:0] HOST_WDATA = 8'h00;
    reg        HOST_WR = 1'b0;
    reg        HOST_RD = 1'b0;
    reg        T1_MODE = 1'b0;
    wire [7:0] HOST_RDATA;
    wire       ten, tsy, tdi, tdo, tbo, ren, rsy, rdi, rdo, rbo;
    wire [7:0] tpos, rpos;
    integer    fails = 0;
    integer    tests_run = 0;
    integer    cyc = 0;
    always #4 CLOCK = ~CLOCK;
    bp_stream_src #(.GAP(4'h2)) bp_stream_src_i (.clk(CLOCK), .rst(RESET),
        .t1(T1_MODE), .bit_en(ten), .sync(tsy), .data(tdi), .pos(tpos));
    bp_stream_src #(.GAP(4'h3)) bp_stream_src_rx_i (.clk(CLOCK),
        .rst(RESET), .t1(T1_MODE), .bit_en(ren), .sync(rsy), .data(rdi),
        .pos(rpos));
    chan_ctrl chan_ctrl_i (.CLOCK(CLOCK), .RESET(RESET),
        .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA), .HOST_WR(HOST_WR),
        .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA), .T1_MODE(T1_MODE),
        .TX_BIT_EN(ten), .TX_FRAME_SYNC(tsy), .TX_DATA_IN(tdi),
        .TX_DATA_OUT(tdo), .TX_CHANNEL_BLOCK_OUT(tbo), .RX_BIT_EN(ren),
        .RX_FRAME_SYNC(rsy), .RX_DATA_IN(rdi), .RX_DATA_OUT(rdo),
        .RX_CHANNEL_BLOCK_OUT(rbo));
    task give_verdict;
        begin
            if (fails == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [7:0] g, input [7:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("Error %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge CLOCK);
            HOST_ADDR  <= a;
            HOST_WDATA <= d;
            HOST_WR    <= 1'b1;
            @(posedge CLOCK);
            HOST_WR    <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge CLOCK);
            HOST_ADDR <= a;
            HOST_RD   <= 1'b1;
            @(posedge CLOCK);
            HOST_RD   <= 1'b0;
            @(negedge CLOCK);
            d = HOST_RDATA;
        end
    endtask
    // Global array write, so every channel of the direction shares code
    task setup(input tx, input [31:0] ins, input [31:0] blk,
               input [7:0] code);
        integer   j;
        reg [7:0] d;
        begin
            wr(8'h7e, tx ? 8'h40 : 8'ha0);
            wr(8'h7f, code);
            rd(8'h7f, d);
            chk(d, code);
            for (j = 0; j < 4; j = j + 1) begin
                wr((tx ? 8'h80 : 8'h84) + j[7:0], ins[8*j +: 8]);
                wr((tx ? 8'h8c : 8'h88) + j[7:0], blk[8*j +: 8]);
            end
        end
    endtask
    task chk_frame(input tx, input [31:0] ins, input [31:0] blk,
                   input [7:0] code);
        integer   k;
        integer   i;
        integer   b;
        reg [7:0] p;
        reg       ed;
        reg       eb;
        begin
            i = 0;
            @(negedge CLOCK);
            while (!(tx ? tsy : rsy) && i < 2000) begin
                @(negedge CLOCK);
                i = i + 1;
            end
            for (k = 0; k < (T1_MODE ? 193 : 256); k = k + 1) begin
                while (!(tx ? ten : ren) && i < 4000) begin
                    @(negedge CLOCK);
                    i = i + 1;
                end
                p  = tx ? tpos : rpos;
                ed = tx ? tdi : rdi;
                eb = 1'b0;
                b  = T1_MODE ? p - 1 : p;
                if (b >= 0) begin
                    if (ins[b / 8])
                        ed = code[7 - b % 8];
                    eb = blk[b / 8];
                end
                @(negedge CLOCK);
                chk({7'h00, tx ? tdo : rdo}, {7'h00, ed});
                chk({7'h00, tx ? tbo : rbo}, {7'h00, eb});
            end
            // A frame that never came counts as a mismatch
            chk({7'h00, i >= 2000}, 8'h00);
        end
    endtask
    task s_regs;
        integer   a;
        reg [7:0] d;
        begin
            for (a = 8'h80; a < 8'h90; a = a + 1) begin
                rd(a[7:0], d);
                chk(d, 8'h00);
                wr(a[7:0], a[7:0] ^ 8'h5a);
                rd(a[7:0], d);
                chk(d, a[7:0] ^ 8'h5a);
            end
            wr(8'h10, 8'hff);
            rd(8'h10, d);
            chk(d, 8'h00);
            // Single-entry writes step the pointer to the next channel
            wr(8'h7e, 8'h02);
            wr(8'h7f, 8'h7e);
            wr(8'h7f, 8'hee);
            rd(8'h7e, d);
            chk(d, 8'h04);
            wr(8'h7e, 8'h03);
            rd(8'h7f, d);
            chk(d, 8'hee);
        end
    endtask
    // First and last channels of each register except channel 24, both directions
    task s_e1;
        begin
            setup(1'b1, 32'h8001_0101, 32'h8000_00c1, 8'ha5);
            chk_frame(1'b1, 32'h8001_0101, 32'h8000_00c1, 8'ha5);
            setup(1'b0, 32'h7f00_fe01, 32'h8001_0003, 8'h3c);
            chk_frame(1'b0, 32'h7f00_fe01, 32'h8001_0003, 8'h3c);
        end
    endtask
    // Bits of channels 25-32 set but absent from the 193-bit frame
    task s_t1;
        begin
            @(posedge CLOCK);
            T1_MODE <= 1'b1;
            setup(1'b1, 32'hff80_0001, 32'hff80_0001, 8'h96);
            chk_frame(1'b1, 32'hff80_0001, 32'hff80_0001, 8'h96);
            // Channel 24 on with code MSB 0, so a substituted F bit shows
            setup(1'b0, 32'hff80_8001, 32'hffff_ffff, 8'h69);
            chk_frame(1'b0, 32'hff80_8001, 32'hffff_ffff, 8'h69);
        end
    endtask
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            give_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge CLOCK);
        RESET <= 1'b0;
        s_regs;
        s_e1;
        s_t1;
        give_verdict;
    end
endmodule

bind chan_ctrl chan_ctrl_props chan_ctrl_props_i (.CLOCK(CLOCK),
    .RESET(RESET), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
    .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_RDATA(HOST_RDATA),
    .T1_MODE(T1_MODE), .TX_BIT_EN(TX_BIT_EN),
    .TX_FRAME_SYNC(TX_FRAME_SYNC), .TX_DATA_OUT(TX_DATA_OUT),
    .TX_CHANNEL_BLOCK_OUT(TX_CHANNEL_BLOCK_OUT), .RX_BIT_EN(RX_BIT_EN),
    .RX_FRAME_SYNC(RX_FRAME_SYNC), .RX_DATA_IN(RX_DATA_IN),
    .RX_DATA_OUT(RX_DATA_OUT),
    .RX_CHANNEL_BLOCK_OUT(RX_CHANNEL_BLOCK_OUT));
